// >>> logic/asc_control.sv
// How it works
// RULE_01 - acquisition lasts 9+2D or 2+2D cycles
// RULE_02 - limit sections hold value and sign
// RULE_03 - watchdog compares one sample against both limits
// RULE_04 - limit bit 9 picks above or below
// RULE_05 - limit bits 10 to 15 ignored
// RULE_06 - config bit 0 reads run status
// RULE_07 - stop takes effect after current instruction
// RULE_08 - start resumes at current instruction pointer
// RULE_09 - reset bit stops, clears pointer, fifo, flags
// RULE_10 - reset bit self-clears after two cycles
// RULE_11 - host waits for reset bit zero
// RULE_12 - short calibration request, immediate or deferred
// RULE_13 - short calibration ends after 76 cycles
// RULE_14 - full calibration request, immediate or deferred
// RULE_15 - full calibration ends after 4944 cycles
// RULE_16 - standby gates clock, keeps memory
// RULE_17 - standby exit equals reset, then completion event
// RULE_18 - memory usable in standby, restart after event
// RULE_19 - fifo tag bits: sign copy or address
// RULE_20 - auto-zero inserted before every operation
// RULE_21 - bit 7 sets trigger pin direction
// RULE_22 - trigger pin high during each operation
// RULE_23 - section pointer picks instruction section
// RULE_24 - test bit kept zero, diagnostic_route_enable gated
// RULE_25 - standby event after 10 ms settling
// RULE_26 - pointer 11 reads zero, ignores writes
`timescale 1ns/1ps
`default_nettype none
module asc_control #(
  parameter int FULL_CAL_LEN = asc_pkg::FULL_CAL_CYCLES,
  parameter int SETTLE_LEN = asc_pkg::SETTLE_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire asc_pkg::asc_bus_s bus_req,
  output logic [asc_pkg::DATA_W-1:0] rd_data,
  input wire logic [12:0] sample_code,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe_n,
  output logic sh_acquire,
  output logic calibrating,
  output logic fifo_push,
  output var asc_pkg::asc_fifo_word_s fifo_word,
  output logic device_clear,
  output logic limit_event,
  output logic limit_which,
  output logic [2:0] limit_instr,
  output logic short_cal_done,
  output logic full_cal_done,
  output logic pause_event,
  output logic standby_done,
  output logic clock_gate_on,
  output logic test_mode,
  output logic diagnostic_route_enable,
  output logic [2:0] instr_pointer
);
  import asc_pkg::*;

  asc_state_e state;
  asc_state_e next_state;
  logic [12:0] cnt;
  logic [12:0] next_cnt;
  logic [19:0] settle_cnt;
  logic settling;
  logic [1:0] reset_cnt;
  logic reset_bit;
  logic run;
  logic stop_req;
  logic short_pend;
  logic full_pend;
  logic standby;
  logic chan_mask;
  logic autoz_every;
  logic sync_dir;
  logic [1:0] sec_ptr;
  logic test_bit;
  logic diagnostic_route_enable_bit;
  logic sync_prev;
  logic signed [8:0] held9;
  logic [15:0] ram_timing [INSTR_DEPTH];
  logic [LIM_USED_W-1:0] ram_lim_one [INSTR_DEPTH];
  logic [LIM_USED_W-1:0] ram_lim_two [INSTR_DEPTH];

  logic ev_instr_end;
  logic ev_push;
  logic ev_cmp1;
  logic ev_cmp2;
  logic ev_pause;
  logic ev_short;
  logic ev_full;

  // host port decode
  wire cfg_sel = bus_req.addr == CFG_ADDR;
  wire ram_sel = !bus_req.addr[RAM_ADDR_BIT];
  wire [2:0] ram_idx = bus_req.addr[2:0];
  wire cfg_wr = bus_req.wr && cfg_sel;
  wire ram_wr = bus_req.wr && ram_sel;
  wire [15:0] wd = bus_req.wdata;
  wire reset_write = cfg_wr && wd[CFG_RESET];
  wire standby_exit = cfg_wr && standby && !wd[CFG_STANDBY];
  wire next_standby = cfg_wr ? wd[CFG_STANDBY] : standby;

  // current instruction fields
  wire [15:0] cur_timing = ram_timing[instr_pointer];
  wire [LIM_USED_W-1:0] cur_lim_one = ram_lim_one[instr_pointer];
  wire [LIM_USED_W-1:0] cur_lim_two = ram_lim_two[instr_pointer];
  wire is_watchdog = cur_timing[SEC0_WATCHDOG];
  wire is_reduced = cur_timing[SEC0_RES8] || is_watchdog;
  wire wait_sync = cur_timing[SEC0_SYNC_WAIT] && !sync_dir;
  wire [3:0] acq_d = cur_timing[SEC0_ACQ_LO +: 4];
  wire [12:0] acq_base = is_reduced ? ACQ_BASE_SHORT : ACQ_BASE_FULL;
  wire [12:0] acq_len = acq_base + {8'h00, acq_d, 1'b0}; // RULE_01
  wire [12:0] conv_len = is_reduced ? 13'(CONV_RED_CYCLES) : 13'(CONV_FULL_CYCLES);
  wire sync_rise = sync_in && !sync_prev; // RULE_21
  wire cnt_zero = cnt == 13'h0000;
  wire run_ok = run && !stop_req;
  wire instr_busy = state == ASC_AUTOZ || state == ASC_ACQ || state == ASC_CONV
                    || state == ASC_CMP1 || state == ASC_CMP2;

  // watchdog compare on sign plus eight magnitude bits, limits as 9-bit two's complement
  wire signed [8:0] sample9 = sample_code[12:4];
  wire signed [8:0] lim_one9 = {cur_lim_one[LIM_SIGN], cur_lim_one[7:0]}; // RULE_02
  wire signed [8:0] lim_two9 = {cur_lim_two[LIM_SIGN], cur_lim_two[7:0]}; // RULE_02
  wire hit_one = cur_lim_one[LIM_DIR] ? (sample9 > lim_one9) : (sample9 < lim_one9); // RULE_04
  wire hit_two = cur_lim_two[LIM_DIR] ? (held9 > lim_two9) : (held9 < lim_two9); // RULE_04

  // register reads; pointer 11 gives zero
  wire [15:0] cfg_rd = {4'h0, diagnostic_route_enable_bit, test_bit, sec_ptr, sync_dir, autoz_every, chan_mask,
                        standby, full_pend, short_pend, reset_bit, run}; // RULE_06
  wire [15:0] ram_rd = (sec_ptr == SEC_TIMING) ? ram_timing[ram_idx] :
                       (sec_ptr == SEC_LIMIT_ONE) ? {6'h00, ram_lim_one[ram_idx]} :
                       (sec_ptr == SEC_LIMIT_TWO) ? {6'h00, ram_lim_two[ram_idx]} :
                       16'h0000; // RULE_26
  wire [15:0] read_mux = cfg_sel ? cfg_rd : (ram_sel ? ram_rd : 16'h0000);

  wire [12:0] push_code = is_reduced ? {sample_code[12:4], 4'h0} : sample_code;
  wire [2:0] push_tag = chan_mask ? {3{sample_code[12]}} : instr_pointer; // RULE_19

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    ev_instr_end = 1'b0;
    ev_push = 1'b0;
    ev_cmp1 = 1'b0;
    ev_cmp2 = 1'b0;
    ev_pause = 1'b0;
    ev_short = 1'b0;
    ev_full = 1'b0;
    if (!cnt_zero) begin
      next_cnt = cnt - 13'h0001;
    end
    if (reset_bit) begin
      next_state = ASC_IDLE; // RULE_09
      next_cnt = 13'h0000;
    end else begin
      unique case (state)
        ASC_IDLE: begin
          if (full_pend) begin
            next_state = ASC_CAL_F; // RULE_14
            next_cnt = 13'(FULL_CAL_LEN - 1);
          end else if (short_pend) begin
            next_state = ASC_CAL_S; // RULE_12
            next_cnt = 13'(SHORT_CAL_CYCLES - 1);
          end else if (run_ok) begin
            next_state = ASC_FETCH; // RULE_08
          end
        end
        ASC_FETCH: begin
          if (full_pend) begin
            next_state = ASC_CAL_F; // RULE_14
            next_cnt = 13'(FULL_CAL_LEN - 1);
          end else if (short_pend) begin
            next_state = ASC_CAL_S; // RULE_12
            next_cnt = 13'(SHORT_CAL_CYCLES - 1);
          end else if (!run_ok) begin
            next_state = ASC_IDLE; // RULE_07
          end else if (cur_timing[SEC0_PAUSE]) begin
            next_state = ASC_IDLE;
            ev_pause = 1'b1;
          end else if (autoz_every) begin
            next_state = ASC_AUTOZ; // RULE_20
            next_cnt = 13'(SHORT_CAL_CYCLES - 1);
          end else if (wait_sync) begin
            next_state = ASC_SYNC;
          end else begin
            next_state = ASC_ACQ;
            next_cnt = acq_len - 13'h0001; // RULE_01
          end
        end
        ASC_AUTOZ: begin
          if (cnt_zero) begin
            next_state = wait_sync ? ASC_SYNC : ASC_ACQ;
            next_cnt = acq_len - 13'h0001;
          end
        end
        ASC_SYNC: begin
          if (!run_ok) begin
            next_state = ASC_IDLE; // RULE_07
          end else if (sync_rise) begin
            next_state = ASC_ACQ; // RULE_21
            next_cnt = acq_len - 13'h0001;
          end
        end
        ASC_ACQ: begin
          if (cnt_zero) begin
            next_state = is_watchdog ? ASC_CMP1 : ASC_CONV; // RULE_03
            next_cnt = is_watchdog ? 13'(CMP_CYCLES - 1) : conv_len - 13'h0001;
          end
        end
        ASC_CONV: begin
          if (cnt_zero) begin
            next_state = ASC_FETCH;
            ev_push = 1'b1;
            ev_instr_end = 1'b1;
          end
        end
        ASC_CMP1: begin
          if (cnt_zero) begin
            next_state = ASC_CMP2; // RULE_03
            next_cnt = 13'(CMP_CYCLES - 1);
            ev_cmp1 = 1'b1;
          end
        end
        ASC_CMP2: begin
          if (cnt_zero) begin
            next_state = ASC_FETCH;
            ev_cmp2 = 1'b1;
            ev_instr_end = 1'b1;
          end
        end
        ASC_CAL_S: begin
          if (cnt_zero) begin
            next_state = run_ok ? ASC_FETCH : ASC_IDLE; // RULE_13
            ev_short = 1'b1;
          end
        end
        ASC_CAL_F: begin
          if (cnt_zero) begin
            next_state = run_ok ? ASC_FETCH : ASC_IDLE; // RULE_15
            ev_full = 1'b1;
          end
        end
        default: begin
          next_state = ASC_IDLE;
          next_cnt = 13'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ASC_IDLE;
      cnt <= 13'h0000;
      sync_prev <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sync_prev <= sync_in;
    end
  end

  // reset bit: set by power-up, a write or standby exit; held during standby
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reset_bit <= 1'b1;
      reset_cnt <= 2'h0;
    end else if (reset_write || standby_exit || next_standby) begin
      reset_bit <= 1'b1; // RULE_17
      reset_cnt <= 2'h0;
    end else if (reset_bit) begin
      reset_cnt <= reset_cnt + 2'h1;
      if (reset_cnt == RESET_HOLD_CYCLES - 2'h1) begin
        reset_bit <= 1'b0; // RULE_10
      end
    end
  end

  // run, stop and calibration requests; a set in the same cycle beats the clear
  always_ff @(posedge clock) begin
    if (sys_rst || reset_bit) begin
      run <= 1'b0; // RULE_09
      stop_req <= 1'b0;
      short_pend <= 1'b0;
      full_pend <= 1'b0;
      instr_pointer <= 3'h0; // RULE_09
    end else begin
      if (cfg_wr && wd[CFG_START]) begin
        run <= 1'b1; // RULE_08
        stop_req <= 1'b0;
      end else if (cfg_wr && run) begin
        stop_req <= 1'b1; // RULE_07
      end else if ((stop_req && !instr_busy) || ev_pause) begin
        run <= 1'b0; // RULE_07
        stop_req <= 1'b0;
      end
      if (cfg_wr && wd[CFG_SHORT_CAL]) begin
        short_pend <= 1'b1; // RULE_12
      end else if (ev_short) begin
        short_pend <= 1'b0; // RULE_13
      end
      if (cfg_wr && wd[CFG_FULL_CAL]) begin
        full_pend <= 1'b1; // RULE_14
      end else if (ev_full) begin
        full_pend <= 1'b0; // RULE_15
      end
      if (ev_instr_end) begin
        instr_pointer <= instr_pointer + 3'h1;
      end
    end
  end

  // plain configuration fields survive the reset bit, only power-up clears them
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      standby <= 1'b0;
      chan_mask <= 1'b0;
      autoz_every <= 1'b0;
      sync_dir <= 1'b0;
      sec_ptr <= SEC_TIMING;
      test_bit <= 1'b0;
      diagnostic_route_enable_bit <= 1'b0;
    end else if (cfg_wr) begin
      standby <= wd[CFG_STANDBY]; // RULE_16
      chan_mask <= wd[CFG_CHAN_MASK];
      autoz_every <= wd[CFG_AUTOZ]; // RULE_20
      sync_dir <= wd[CFG_SYNC_DIR]; // RULE_21
      sec_ptr <= wd[CFG_PTR_LO +: 2]; // RULE_23
      test_bit <= wd[CFG_TEST]; // RULE_24
      diagnostic_route_enable_bit <= wd[CFG_DIAGNOSTIC_ROUTE_ENABLE];
    end
  end

  // instruction memory stays writable in standby
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < INSTR_DEPTH; i++) begin
        ram_timing[i] <= 16'h0000;
        ram_lim_one[i] <= 10'h000;
        ram_lim_two[i] <= 10'h000;
      end
    end else if (ram_wr) begin
      unique case (sec_ptr) // RULE_23
        SEC_TIMING: ram_timing[ram_idx] <= wd; // RULE_18
        SEC_LIMIT_ONE: ram_lim_one[ram_idx] <= wd[LIM_USED_W-1:0]; // RULE_05
        SEC_LIMIT_TWO: ram_lim_two[ram_idx] <= wd[LIM_USED_W-1:0]; // RULE_05
        default: ram_timing[ram_idx] <= ram_timing[ram_idx]; // RULE_26
      endcase
    end
  end

  // analog settling after standby; re-entering standby cancels it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      settling <= 1'b0;
      settle_cnt <= 20'h00000;
      standby_done <= 1'b0;
    end else begin
      standby_done <= 1'b0;
      if (standby_exit) begin
        settling <= 1'b1;
        settle_cnt <= 20'(SETTLE_LEN - 1);
      end else if (next_standby) begin
        settling <= 1'b0;
      end else if (settling) begin
        if (settle_cnt == 20'h00000) begin
          settling <= 1'b0;
          standby_done <= 1'b1; // RULE_25
        end else begin
          settle_cnt <= settle_cnt - 20'h00001;
        end
      end
    end
  end

  // registered outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_data <= 16'h0000;
      sync_out <= 1'b0;
      sync_oe_n <= 1'b1;
      sh_acquire <= 1'b0;
      calibrating <= 1'b0;
      fifo_push <= 1'b0;
      fifo_word <= '0;
      device_clear <= 1'b1;
      limit_event <= 1'b0;
      limit_which <= 1'b0;
      limit_instr <= 3'h0;
      short_cal_done <= 1'b0;
      full_cal_done <= 1'b0;
      pause_event <= 1'b0;
      clock_gate_on <= 1'b1;
      test_mode <= 1'b0;
      diagnostic_route_enable <= 1'b0;
    end else begin
      if (bus_req.rd) begin
        rd_data <= read_mux;
      end
      sync_out <= sync_dir && (next_state == ASC_ACQ || next_state == ASC_CONV
                  || next_state == ASC_CMP1 || next_state == ASC_CMP2); // RULE_22
      sync_oe_n <= !(cfg_wr ? wd[CFG_SYNC_DIR] : sync_dir); // RULE_21
      sh_acquire <= next_state == ASC_ACQ; // RULE_01
      calibrating <= next_state == ASC_CAL_S || next_state == ASC_CAL_F || next_state == ASC_AUTOZ;
      fifo_push <= ev_push;
      if (ev_push) begin
        fifo_word <= '{tag: push_tag, code: push_code}; // RULE_19
      end
      device_clear <= reset_bit; // RULE_09
      limit_event <= (ev_cmp1 && hit_one) || (ev_cmp2 && hit_two); // RULE_03
      if (ev_cmp1) begin
        held9 <= sample9; // RULE_03
      end
      if ((ev_cmp1 && hit_one) || (ev_cmp2 && hit_two)) begin
        limit_which <= ev_cmp2;
        limit_instr <= instr_pointer;
      end
      short_cal_done <= ev_short; // RULE_13
      full_cal_done <= ev_full; // RULE_15
      pause_event <= ev_pause;
      clock_gate_on <= !next_standby; // RULE_16
      test_mode <= test_bit;
      diagnostic_route_enable <= diagnostic_route_enable_bit && !test_bit; // RULE_24
    end
  end

endmodule
`default_nettype wire

// >>> common/asc_pkg.sv
`default_nettype none
package asc_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int INSTR_DEPTH = 8;

  // word addresses on the host port
  localparam logic [3:0] CFG_ADDR = 4'h8;
  localparam int RAM_ADDR_BIT = 3;

  // configuration bit positions
  localparam int CFG_START = 0;
  localparam int CFG_RESET = 1;
  localparam int CFG_SHORT_CAL = 2;
  localparam int CFG_FULL_CAL = 3;
  localparam int CFG_STANDBY = 4;
  localparam int CFG_CHAN_MASK = 5;
  localparam int CFG_AUTOZ = 6;
  localparam int CFG_SYNC_DIR = 7;
  localparam int CFG_PTR_LO = 8;
  localparam int CFG_TEST = 10;
  localparam int CFG_DIAGNOSTIC_ROUTE_ENABLE = 11;

  // section pointer codes
  localparam logic [1:0] SEC_TIMING = 2'h0;
  localparam logic [1:0] SEC_LIMIT_ONE = 2'h1;
  localparam logic [1:0] SEC_LIMIT_TWO = 2'h2;

  // timing section fields
  localparam int SEC0_PAUSE = 1;
  localparam int SEC0_SYNC_WAIT = 8;
  localparam int SEC0_RES8 = 10;
  localparam int SEC0_WATCHDOG = 11;
  localparam int SEC0_ACQ_LO = 12;

  // limit section fields
  localparam int LIM_SIGN = 8;
  localparam int LIM_DIR = 9;
  localparam int LIM_USED_W = 10;

  // timing, in clock cycles unless named otherwise
  localparam logic [12:0] ACQ_BASE_FULL = 13'h0009;
  localparam logic [12:0] ACQ_BASE_SHORT = 13'h0002;
  localparam logic [1:0] RESET_HOLD_CYCLES = 2'h2;
  localparam int SHORT_CAL_CYCLES = 76;
  localparam int FULL_CAL_CYCLES = 4944;
  localparam int CONV_FULL_CYCLES = 44;
  localparam int CONV_RED_CYCLES = 21;
  localparam int CMP_CYCLES = 4;
  localparam int SETTLE_TIME_US = 10_000;
  localparam int SETTLE_CYCLES = SETTLE_TIME_US * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asc_bus_s;

  typedef struct packed {
    logic [2:0] tag;
    logic [12:0] code;
  } asc_fifo_word_s;

  typedef enum logic [3:0] {
    ASC_IDLE = 4'h0,
    ASC_FETCH = 4'h1,
    ASC_AUTOZ = 4'h2,
    ASC_SYNC = 4'h3,
    ASC_ACQ = 4'h4,
    ASC_CONV = 4'h5,
    ASC_CMP1 = 4'h6,
    ASC_CMP2 = 4'h7,
    ASC_CAL_S = 4'h8,
    ASC_CAL_F = 4'h9
  } asc_state_e;

endpackage
`default_nettype wire

// >>> test/asc_host.sv
`timescale 1ns/1ps
`default_nettype none
module asc_host (
  input wire logic clock,
  input wire logic [asc_pkg::DATA_W-1:0] rd_data,
  output var asc_pkg::asc_bus_s bus_req
);
  import asc_pkg::*;

  initial bus_req = '0;

  // one strobe cycle; data lines flipped on release so stale values never look valid
  task automatic put(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_req.wr <= w;
    bus_req.rd <= !w;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge clock);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    bus_req.wdata <= ~d;
  endtask

  task automatic write(input logic [3:0] a, input logic [15:0] d);
    put(1'b1, a, d);
  endtask

  task automatic read(input logic [3:0] a, output logic [15:0] d);
    put(1'b0, a, 16'h0000);
    #1;
    d = rd_data;
  endtask

  // nothing is started before the reset bit reads zero or ten reads have passed
  task automatic wait_ready;
    logic [15:0] v;
    v = 16'hFFFF;
    for (int i = 0; i < 10 && v[CFG_RESET] !== 1'b0; i++) begin
      read(CFG_ADDR, v);
    end
  endtask
endmodule
`default_nettype wire

// >>> test/asc_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module asc_control_asserts #(
  parameter int FULL_CAL_LEN = 4944,
  parameter int SETTLE_LEN = 500000
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire asc_pkg::asc_bus_s bus_req,
  input wire logic sync_oe_n,
  input wire logic calibrating,
  input wire logic fifo_push,
  input wire asc_pkg::asc_fifo_word_s fifo_word,
  input wire logic device_clear,
  input wire logic short_cal_done,
  input wire logic full_cal_done,
  input wire logic standby_done,
  input wire logic limit_event,
  input wire logic clock_gate_on,
  input wire logic test_mode,
  input wire logic diagnostic_route_enable,
  input wire logic [2:0] instr_pointer
);
  import asc_pkg::*;
  int cal_cnt;
  int cal_last;
  int gate_cnt;
  int cal_len;
  logic mask_q;
  wire cfg_wr = bus_req.wr && bus_req.addr == CFG_ADDR;
  // done pulse may land a cycle after the counter has already cleared
  assign cal_len = (cal_cnt != 0) ? cal_cnt : cal_last;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cal_cnt <= 0;
      cal_last <= 0;
      gate_cnt <= 0;
      mask_q <= 1'b0;
    end else begin
      cal_cnt <= calibrating ? cal_cnt + 1 : 0;
      if (!calibrating && cal_cnt != 0)
        cal_last <= cal_cnt;
      gate_cnt <= !clock_gate_on ? 0 : (gate_cnt < 2000000 ? gate_cnt + 1 : gate_cnt);
      if (cfg_wr)
        mask_q <= bus_req.wdata[CFG_CHAN_MASK];
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_diagnostic_route_enable_gated: assert property (diagnostic_route_enable |-> !test_mode)
    else $error("diagnostic_route_enable route active in test mode");
  a_sync_dir: assert property (cfg_wr |=> sync_oe_n == !$past(bus_req.wdata[CFG_SYNC_DIR]))
    else $error("trigger pin direction wrong");
  a_reset_pulse: assert property ($rose(device_clear) && clock_gate_on |-> device_clear [*2] ##1 !device_clear)
    else $error("reset bit length wrong");
  a_reset_ptr: assert property ($rose(device_clear) |-> ##[0:2] instr_pointer == 3'h0)
    else $error("pointer not cleared by reset");
  a_short_len: assert property (short_cal_done |-> cal_len == SHORT_CAL_CYCLES)
    else $error("short calibration length wrong");
  a_full_len: assert property (full_cal_done |-> cal_len == FULL_CAL_LEN)
    else $error("full calibration length wrong");
  a_standby_gate: assert property (cfg_wr && bus_req.wdata[CFG_STANDBY] |=> !clock_gate_on)
    else $error("clock not gated in standby");
  a_settle_delay: assert property (standby_done |-> gate_cnt >= SETTLE_LEN && gate_cnt <= SETTLE_LEN + 1)
    else $error("standby return delay wrong");
  a_tag_sign: assert property (fifo_push && mask_q |-> fifo_word.tag == {3{fifo_word.code[12]}})
    else $error("masked tag is not the sign");

  c_short: cover property (short_cal_done);
  c_full: cover property (full_cal_done);
  c_standby: cover property (standby_done);
  c_limit: cover property (limit_event);
endmodule
bind asc_control asc_control_asserts #(.FULL_CAL_LEN(FULL_CAL_LEN), .SETTLE_LEN(SETTLE_LEN)) u_asc_control_asserts (
  .clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .sync_oe_n(sync_oe_n), .calibrating(calibrating),
  .fifo_push(fifo_push), .fifo_word(fifo_word), .device_clear(device_clear), .short_cal_done(short_cal_done),
  .full_cal_done(full_cal_done), .standby_done(standby_done), .limit_event(limit_event),
  .clock_gate_on(clock_gate_on), .test_mode(test_mode), .diagnostic_route_enable(diagnostic_route_enable),
  .instr_pointer(instr_pointer));
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asc_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [12:0] sample_code = 13'h0100;
  logic sync_in = 1'b0;
  asc_bus_s bus_req;
  asc_fifo_word_s fifo_word;
  logic [15:0] rd_data, rv;
  logic sync_oe_n, sh_acquire, calibrating, fifo_push, limit_event, limit_which, short_cal_done, full_cal_done;
  logic pause_event, standby_done, clock_gate_on, test_mode, diagnostic_route_enable_en, cal_d, sync_out;
  logic [2:0] limit_instr, instr_pointer;
  int fail_count, checks, acq_n, cal_rises, lim_n, n, so_n;
  int evn[6];
  int acq_q[$];
  logic [2:0] tag_q[$];
  logic [15:0] wv[4] = '{16'hF123, 16'hFD5A, 16'hFE77, 16'hFFFF};
  logic [15:0] ev[4] = '{16'hF123, 16'h015A, 16'h0277, 16'h0000};
  int acq_exp[3] = '{15, 6, 4};

  asc_control #(.FULL_CAL_LEN(40), .SETTLE_LEN(20)) u_asc_control (
    .clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data), .sample_code(sample_code),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n(sync_oe_n), .sh_acquire(sh_acquire), .calibrating(calibrating),
    .fifo_push(fifo_push), .fifo_word(fifo_word), .device_clear(), .limit_event(limit_event),
    .limit_which(limit_which), .limit_instr(limit_instr), .short_cal_done(short_cal_done),
    .full_cal_done(full_cal_done), .pause_event(pause_event), .standby_done(standby_done),
    .clock_gate_on(clock_gate_on), .test_mode(test_mode), .diagnostic_route_enable(diagnostic_route_enable_en),
    .instr_pointer(instr_pointer));
  asc_host u_asc_host (.clock(clock), .rd_data(rd_data), .bus_req(bus_req));

  always #10 clock = ~clock;

  always @(posedge clock) begin
    if (pause_event === 1'b1) evn[0]++;
    if (short_cal_done === 1'b1) evn[1]++;
    if (full_cal_done === 1'b1) evn[2]++;
    if (standby_done === 1'b1) evn[3]++;
    if (limit_event === 1'b1) lim_n++;
    if (sync_out === 1'b1) so_n++;
    if (fifo_push === 1'b1) begin
      evn[4]++;
      tag_q.push_back(fifo_word.tag);
    end
    if (sh_acquire === 1'b1) begin
      if (acq_n == 0) evn[5]++;
      acq_n++;
    end else if (acq_n != 0) begin
      acq_q.push_back(acq_n);
      acq_n = 0;
    end
    if (calibrating === 1'b1 && !cal_d) cal_rises++;
    cal_d = (calibrating === 1'b1);
  end

  task automatic chk_word(string w, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_int(string w, int e, int g);
    checks++;
    if (g != e) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", w, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    u_asc_host.write(a, d);
  endtask
  task automatic cfg_is(string w, logic [15:0] e);
    u_asc_host.read(CFG_ADDR, rv);
    chk_word(w, e, rv);
  endtask
  task automatic wait_ev(int i, int tgt);
    for (int k = 0; k < 20000 && evn[i] < tgt; k++) @(posedge clock);
    #1;
    chk_int("event count", tgt, evn[i]);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // whole run is under a thousand cycles; 30000 cycles means a hang
  initial begin
    repeat (30000) @(posedge clock);
    fail_count++;
    finish_test;
  end

  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    u_asc_host.wait_ready;
    cfg_is("cfg after power up", 16'h0000);
    for (int p = 0; p < 4; p++) begin
      wr(CFG_ADDR, 16'(p) << 8);
      wr(4'h3, wv[p]);
    end
    for (int p = 0; p < 4; p++) begin
      wr(CFG_ADDR, 16'(p) << 8);
      u_asc_host.read(4'h3, rv);
      chk_word("ram section", ev[p], rv);
    end
    $display("test sections end");
    wr(CFG_ADDR, 16'h0000);
    wr(4'h0, 16'h3000);
    wr(4'h1, 16'h2400);
    wr(4'h2, 16'h1800);
    wr(4'h3, 16'h0002);
    wr(CFG_ADDR, 16'h0100);
    wr(4'h2, 16'h0200);
    wr(CFG_ADDR, 16'h0200);
    wr(4'h2, 16'hFC05);
    acq_q.delete();
    tag_q.delete();
    cal_rises = 0;
    wr(CFG_ADDR, 16'h00C1);
    wait_ev(0, 1);
    cfg_is("cfg at pause", 16'h00C0);
    for (int i = 0; i < 3; i++) chk_int("acq length", acq_exp[i], acq_q[i]);
    chk_int("auto zero count", 3, cal_rises);
    chk_int("limit hits", 1, lim_n);
    chk_word("limit which", 16'h0000, {15'h0, limit_which});
    chk_word("limit instr", 16'h0002, {13'h0, limit_instr});
    chk_word("tag 0", 16'h0000, {13'h0, tag_q[0]});
    chk_word("tag 1", 16'h0001, {13'h0, tag_q[1]});
    chk_word("pin enable", 16'h0000, {15'h0, sync_oe_n});
    chk_int("trigger high", 98, so_n);
    $display("test sequence end");
    wr(CFG_ADDR, 16'h0082);
    u_asc_host.wait_ready;
    cfg_is("cfg after reset", 16'h0080);
    chk_word("pointer after reset", 16'h0000, {13'h0, instr_pointer});
    n = evn[5] + 1;
    wr(CFG_ADDR, 16'h0081);
    wait_ev(5, n);
    n = evn[4] + 1;
    wr(CFG_ADDR, 16'h0080);
    cfg_is("run while finishing", 16'h0081);
    wait_ev(4, n);
    cfg_is("run after stop", 16'h0080);
    chk_word("pointer after stop", 16'h0001, {13'h0, instr_pointer});
    @(posedge clock);
    sample_code <= 13'h1F00;
    acq_q.delete();
    tag_q.delete();
    n = evn[4] + 1;
    wr(CFG_ADDR, 16'h00A1);
    wait_ev(4, n);
    chk_int("resumed acq", 6, acq_q[0]);
    chk_word("masked tag", 16'h0007, {13'h0, tag_q[0]});
    wr(CFG_ADDR, 16'h00A2);
    u_asc_host.wait_ready;
    cfg_is("cfg after mid reset", 16'h00A0);
    chk_word("pointer mid reset", 16'h0000, {13'h0, instr_pointer});
    $display("test stop end");
    for (int b = 2; b < 4; b++) begin
      n = evn[b - 1] + 1;
      wr(CFG_ADDR, 16'h00A0 | (16'h0001 << b));
      cfg_is("cal pending", 16'h00A0 | (16'h0001 << b));
      wait_ev(b - 1, n);
      cfg_is("cal cleared", 16'h00A0);
    end
    $display("test calibration end");
    wr(CFG_ADDR, 16'h00B0);
    cfg_is("cfg in standby", 16'h00B2);
    chk_word("clock gated", 16'h0000, {15'h0, clock_gate_on});
    wr(4'h0, 16'h4321);
    u_asc_host.read(4'h0, rv);
    chk_word("ram in standby", 16'h4321, rv);
    n = evn[3] + 1;
    wr(CFG_ADDR, 16'h00A0);
    wait_ev(3, n);
    chk_word("clock running", 16'h0001, {15'h0, clock_gate_on});
    u_asc_host.wait_ready;
    cfg_is("cfg after standby", 16'h00A0);
    u_asc_host.read(4'h0, rv);
    chk_word("ram kept", 16'h4321, rv);
    wr(CFG_ADDR, 16'h0001);
    n = evn[5];
    repeat (9) @(posedge clock);
    chk_int("acq before edge", n, evn[5]);
    sync_in <= 1'b1;
    wait_ev(5, n + 1);
    wr(CFG_ADDR, 16'h0002);
    u_asc_host.wait_ready;
    $display("test standby end");
    wr(CFG_ADDR, 16'hF8A0);
    cfg_is("cfg high bits", 16'h08A0);
    chk_word("diagnostic_route_enable route", 16'h0001, {15'h0, diagnostic_route_enable_en});
    chk_word("test mode", 16'h0000, {15'h0, test_mode});
    wr(4'h9, 16'hFFFF);
    u_asc_host.read(4'h9, rv);
    chk_word("unmapped read", 16'h0000, rv);
    $display("test misc end");
    finish_test;
  end
endmodule
`default_nettype wire
